// ### verilog/omlc_pkg.sv
// constants for the low operating mode control bits
`default_nettype none
package omlc_pkg;
  // register width and field positions
  localparam int OMLC_REG_W = 24;
  localparam int OMLC_BURST_BIT = 10;
  localparam int OMLC_PRIO_LSB = 8;
  localparam int OMLC_SWITCH_BIT = 7;
  localparam int OMLC_STOPSEL_BIT = 6;
  localparam int OMLC_RSVD_BIT = 5;
  localparam int OMLC_BUSOFF_BIT = 4;
  localparam int OMLC_MODE_LSB = 0;
  localparam int OMLC_MODE_W = 4;
  // values after reset
  localparam logic OMLC_BURST_RESET = 1'b0;
  localparam logic [1:0] OMLC_PRIO_RESET = 2'h3;
  localparam logic OMLC_SWITCH_RESET = 1'b0;
  localparam logic OMLC_STOPSEL_RESET = 1'b0;
  localparam logic OMLC_BUSOFF_RESET = 1'b0;
  localparam logic [3:0] OMLC_MODE_RESET = 4'h0;
  // core versus dma priority encodings
  localparam logic [1:0] OMLC_PRIO_COMPARE = 2'h0;
  localparam logic [1:0] OMLC_PRIO_DMA_FIRST = 2'h1;
  localparam logic [1:0] OMLC_PRIO_EQUAL = 2'h2;
  localparam logic [1:0] OMLC_PRIO_CORE_FIRST = 2'h3;
  // words per cache miss
  localparam logic [2:0] OMLC_SINGLE_WORDS = 3'h1;
  localparam logic [2:0] OMLC_BURST_WORDS = 3'h4;
  // stop exit delays in clock cycles
  localparam int OMLC_STOP_LONG_CYCLES = 128 * 1024;
  localparam int OMLC_STOP_SHORT_CYCLES = 16;
  localparam int OMLC_DELAY_W = 18;
  // cache fetch sequencer states
  typedef enum logic [0:0] {OMLC_FETCH_IDLE, OMLC_FETCH_BUSY} omlc_fetch_e;
endpackage
`default_nettype wire

// ### verilog/omlc_delay_counter.sv
// down counter that pulses done a loaded number of cycles after start
`default_nettype none
module omlc_delay_counter #(
  parameter int WIDTH = 18
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [WIDTH-1:0] load_value,
  output logic busy,
  output logic done
);
  logic [WIDTH-1:0] count;

  // load on start when idle, count down, pulse done on the last step
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      done <= 1'b0;
    end else begin
      done <= (count == WIDTH'(1));
      if (start && count == '0) begin
        count <= load_value;
      end else if (count != '0) begin
        count <= count - WIDTH'(1);
      end
    end
  end

  assign busy = (count != '0);
endmodule
`default_nettype wire

// ### verilog/omlc_ctrl.sv
// low operating mode control bits with fetch, arbitration and stop exit logic
`default_nettype none
// Overview of operation
// R01 - burst enable clear: a cache miss fetches exactly one external word
// R02 - burst enable set: a cache miss fetches up to four words in a burst
// R03 - two-bit core/dma priority field selects bus priority, resets to 11
// R04 - field 00: compare core priority bits with active dma channel priority
// R05 - field 01: dma requests win over core requests
// R06 - field 10: dma and core requests share equal priority
// R07 - field 11: core requests win over dma requests
// R08 - memory switch mode lends part of data memory to program ram
// R09 - cache always sits at top of program ram, moving with switch mode
// R10 - software places six no-ops after changing memory switch mode
// R11 - software never sets switch mode while the cache is enabled
// R12 - stop delay select clear: stop exit waits 128K cycles
// R13 - stop delay select set: stop exit waits 16 cycles
// R14 - software writes zero to reserved bit 5, which resets to zero
// R15 - external bus off set disables external bus and all external accesses
// R16 - hardware reset clears external bus off
// R17 - reset loads chip mode bits from the four mode pins, high to bit 3
// R18 - after reset the chip mode bits are writable and hold the value
// R19 - reads return every control bit, reserved bit reading zero
module omlc_ctrl import omlc_pkg::*; #(
  parameter int STOP_LONG_CYCLES = OMLC_STOP_LONG_CYCLES,
  parameter int PRAM_BASE_WORDS = 4096,
  parameter int SWITCH_WORDS = 2048,
  parameter int CACHE_WORDS = 1024,
  parameter int ADDR_W = 16
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic REG_WR_EN,
  input wire logic [OMLC_REG_W-1:0] REG_WR_DATA,
  output logic [OMLC_REG_W-1:0] REG_RD_DATA,
  input wire logic MODE_PIN_HIGH,
  input wire logic MODE_PIN_TWO,
  input wire logic MODE_PIN_ONE,
  input wire logic MODE_PIN_LOW,
  output logic [OMLC_MODE_W-1:0] CHIP_MODE_BITS,
  output logic MEMORY_SWITCH_MODE,
  output logic [ADDR_W-1:0] PRAM_WORDS,
  output logic [ADDR_W-1:0] CACHE_BASE_ADDR,
  output logic EXT_BUS_ENABLE,
  input wire logic CACHE_MISS,
  output logic FETCH_REQ,
  input wire logic FETCH_ACK,
  output logic FETCH_DONE,
  input wire logic CORE_BUS_REQ,
  input wire logic DMA_BUS_REQ,
  input wire logic [1:0] CORE_PRIORITY_FIELD,
  input wire logic [1:0] DMA_CHANNEL_PRIORITY,
  output logic CORE_BUS_GRANT,
  output logic DMA_BUS_GRANT,
  input wire logic STOP_EXIT,
  output logic STOP_WAITING,
  output logic CORE_RESUME
);
  logic burst_fetch_enable;
  logic [1:0] core_dma_priority_select;
  logic memory_switch_mode;
  logic stop_delay_select;
  logic external_bus_off;
  logic [OMLC_MODE_W-1:0] chip_mode_bits;
  logic mode_load_pending;
  omlc_fetch_e fetch_state;
  logic [2:0] words_left;
  logic rr_dma_turn;
  logic core_win;
  logic delay_busy;
  logic [OMLC_DELAY_W-1:0] delay_load;

  ////////////////////////////////////////////////////////////////////////////
  // control register

  // control bits, written by software
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      burst_fetch_enable <= OMLC_BURST_RESET;
      core_dma_priority_select <= OMLC_PRIO_RESET; // R03
      memory_switch_mode <= OMLC_SWITCH_RESET;
      stop_delay_select <= OMLC_STOPSEL_RESET;
      external_bus_off <= OMLC_BUSOFF_RESET; // R16
    end else if (REG_WR_EN) begin
      burst_fetch_enable <= REG_WR_DATA[OMLC_BURST_BIT];
      core_dma_priority_select <= REG_WR_DATA[OMLC_PRIO_LSB +: 2];
      memory_switch_mode <= REG_WR_DATA[OMLC_SWITCH_BIT]; // R08
      stop_delay_select <= REG_WR_DATA[OMLC_STOPSEL_BIT];
      external_bus_off <= REG_WR_DATA[OMLC_BUSOFF_BIT]; // R15
    end
  end

  // mode pins caught at the first edge after reset release
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      mode_load_pending <= 1'b1;
      chip_mode_bits <= OMLC_MODE_RESET;
    end else begin
      mode_load_pending <= 1'b0;
      if (mode_load_pending) begin
        chip_mode_bits <= {MODE_PIN_HIGH, MODE_PIN_TWO, MODE_PIN_ONE, MODE_PIN_LOW}; // R17
      end else if (REG_WR_EN) begin
        chip_mode_bits <= REG_WR_DATA[OMLC_MODE_LSB +: OMLC_MODE_W]; // R18
      end
    end
  end

  // read back, reserved and upper bits zero
  always_comb begin
    REG_RD_DATA = '0;
    REG_RD_DATA[OMLC_BURST_BIT] = burst_fetch_enable; // R19
    REG_RD_DATA[OMLC_PRIO_LSB +: 2] = core_dma_priority_select;
    REG_RD_DATA[OMLC_SWITCH_BIT] = memory_switch_mode;
    REG_RD_DATA[OMLC_STOPSEL_BIT] = stop_delay_select;
    REG_RD_DATA[OMLC_RSVD_BIT] = 1'b0; // R14
    REG_RD_DATA[OMLC_BUSOFF_BIT] = external_bus_off;
    REG_RD_DATA[OMLC_MODE_LSB +: OMLC_MODE_W] = chip_mode_bits;
  end

  assign CHIP_MODE_BITS = chip_mode_bits;
  assign MEMORY_SWITCH_MODE = memory_switch_mode;
  assign EXT_BUS_ENABLE = ~external_bus_off;

  ////////////////////////////////////////////////////////////////////////////
  // program ram map

  // ram grows by the switched words, cache stays at the top
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      PRAM_WORDS <= ADDR_W'(PRAM_BASE_WORDS);
      CACHE_BASE_ADDR <= ADDR_W'(PRAM_BASE_WORDS - CACHE_WORDS);
    end else if (memory_switch_mode) begin
      PRAM_WORDS <= ADDR_W'(PRAM_BASE_WORDS + SWITCH_WORDS); // R08
      CACHE_BASE_ADDR <= ADDR_W'(PRAM_BASE_WORDS + SWITCH_WORDS - CACHE_WORDS); // R09
    end else begin
      PRAM_WORDS <= ADDR_W'(PRAM_BASE_WORDS);
      CACHE_BASE_ADDR <= ADDR_W'(PRAM_BASE_WORDS - CACHE_WORDS); // R09
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cache miss fetch sequencer

  // one word or a four word burst per miss, none while the bus is off
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      fetch_state <= OMLC_FETCH_IDLE;
      words_left <= 3'h0;
      FETCH_DONE <= 1'b0;
    end else begin
      FETCH_DONE <= 1'b0;
      case (fetch_state)
        OMLC_FETCH_IDLE: begin
          if (CACHE_MISS && !external_bus_off) begin // R15
            words_left <= burst_fetch_enable ? OMLC_BURST_WORDS : OMLC_SINGLE_WORDS; // R01 R02
            fetch_state <= OMLC_FETCH_BUSY;
          end
        end
        OMLC_FETCH_BUSY: begin
          if (FETCH_ACK) begin
            words_left <= words_left - 3'h1;
            if (words_left == 3'h1) begin
              FETCH_DONE <= 1'b1;
              fetch_state <= OMLC_FETCH_IDLE;
            end
          end
        end
        default: fetch_state <= OMLC_FETCH_IDLE;
      endcase
    end
  end

  assign FETCH_REQ = (fetch_state == OMLC_FETCH_BUSY) && !external_bus_off; // R15

  ////////////////////////////////////////////////////////////////////////////
  // core versus dma external bus arbitration

  // pick the winner when both request
  always_comb begin
    case (core_dma_priority_select)
      OMLC_PRIO_COMPARE: begin
        if (CORE_PRIORITY_FIELD != DMA_CHANNEL_PRIORITY) begin
          core_win = CORE_PRIORITY_FIELD > DMA_CHANNEL_PRIORITY; // R04
        end else begin
          core_win = !rr_dma_turn;
        end
      end
      OMLC_PRIO_DMA_FIRST: core_win = 1'b0; // R05
      OMLC_PRIO_EQUAL: core_win = !rr_dma_turn; // R06
      OMLC_PRIO_CORE_FIRST: core_win = 1'b1; // R07
      default: core_win = 1'b1;
    endcase
  end

  assign CORE_BUS_GRANT = !external_bus_off && CORE_BUS_REQ && (!DMA_BUS_REQ || core_win); // R15
  assign DMA_BUS_GRANT = !external_bus_off && DMA_BUS_REQ && (!CORE_BUS_REQ || !core_win);

  // alternate turns after each contested grant
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rr_dma_turn <= 1'b0;
    end else if (CORE_BUS_GRANT && DMA_BUS_REQ) begin
      rr_dma_turn <= 1'b1; // R06
    end else if (DMA_BUS_GRANT && CORE_BUS_REQ) begin
      rr_dma_turn <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stop exit delay

  assign delay_load = stop_delay_select ? OMLC_DELAY_W'(OMLC_STOP_SHORT_CYCLES) // R13
                                        : OMLC_DELAY_W'(STOP_LONG_CYCLES); // R12

  omlc_delay_counter #(
    .WIDTH(OMLC_DELAY_W)
  ) u_stop_delay (
    .clk(CLOCK),
    .rst(RST),
    .start(STOP_EXIT),
    .load_value(delay_load),
    .busy(delay_busy),
    .done(CORE_RESUME)
  );

  assign STOP_WAITING = delay_busy;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);

  a_prio_write_hold: assert property ( // R03
    REG_WR_EN |=> core_dma_priority_select == $past(REG_WR_DATA[OMLC_PRIO_LSB +: 2]))
    else $error("priority field did not take written value");
  a_single_word: assert property ( // R01
    (fetch_state == OMLC_FETCH_IDLE && CACHE_MISS && !external_bus_off
     && !burst_fetch_enable) |=> words_left == 3'h1)
    else $error("single fetch not one word");
  a_burst_words: assert property ( // R02
    (fetch_state == OMLC_FETCH_IDLE && CACHE_MISS && !external_bus_off
     && burst_fetch_enable) |=> words_left == 3'h4)
    else $error("burst fetch not four words");
  a_bus_off_quiet: assert property ( // R15
    external_bus_off |-> !CORE_BUS_GRANT && !DMA_BUS_GRANT && !FETCH_REQ)
    else $error("external activity while bus off");
  a_dma_first: assert property ( // R05
    (core_dma_priority_select == OMLC_PRIO_DMA_FIRST && CORE_BUS_REQ && DMA_BUS_REQ
     && !external_bus_off) |-> DMA_BUS_GRANT && !CORE_BUS_GRANT)
    else $error("dma did not win");
  a_core_first: assert property ( // R07
    (core_dma_priority_select == OMLC_PRIO_CORE_FIRST && CORE_BUS_REQ && DMA_BUS_REQ
     && !external_bus_off) |-> CORE_BUS_GRANT && !DMA_BUS_GRANT)
    else $error("core did not win");
  a_equal_alternate: assert property ( // R06
    (core_dma_priority_select == OMLC_PRIO_EQUAL && CORE_BUS_GRANT && DMA_BUS_REQ)
    ##1 (core_dma_priority_select == OMLC_PRIO_EQUAL && CORE_BUS_REQ && DMA_BUS_REQ
    && !external_bus_off) |-> DMA_BUS_GRANT)
    else $error("equal priority did not alternate");
  a_compare_prio: assert property ( // R04
    (core_dma_priority_select == OMLC_PRIO_COMPARE && CORE_BUS_REQ && DMA_BUS_REQ
     && !external_bus_off && CORE_PRIORITY_FIELD > DMA_CHANNEL_PRIORITY) |-> CORE_BUS_GRANT)
    else $error("higher core priority lost");
  // sixteen waiting cycles after the taking edge, resume pulse in the next one
  a_short_stop: assert property ( // R13
    (STOP_EXIT && !delay_busy && stop_delay_select) |=> !CORE_RESUME [*8] ##1
      !CORE_RESUME [*8] ##1 CORE_RESUME)
    else $error("short stop delay not 16 cycles");
  // sampled reset keeps the release edge itself out of the check
  a_mode_pins: assert property ( // R17
    (!RST && mode_load_pending) |=> chip_mode_bits
      == $past({MODE_PIN_HIGH, MODE_PIN_TWO, MODE_PIN_ONE, MODE_PIN_LOW}))
    else $error("mode bits not loaded from pins");
  a_reserved_zero: assert property ( // R19
    REG_RD_DATA[OMLC_RSVD_BIT] == 1'b0 && REG_RD_DATA[OMLC_BURST_BIT] == burst_fetch_enable)
    else $error("read back mismatch");
  a_cache_top: assert property ( // R09
    memory_switch_mode ##1 memory_switch_mode |-> CACHE_BASE_ADDR + ADDR_W'(CACHE_WORDS)
      == PRAM_WORDS && PRAM_WORDS == ADDR_W'(PRAM_BASE_WORDS + SWITCH_WORDS))
    else $error("cache not at top of program ram");

  c_burst_fetch: cover property (burst_fetch_enable && FETCH_DONE);
  c_dma_win: cover property (DMA_BUS_GRANT && CORE_BUS_REQ);
  c_stop_resume: cover property (CORE_RESUME);
  c_switch_mode: cover property (memory_switch_mode);
endmodule
`default_nettype wire

// ### testbench/test_operating_mode_low_control.sv
// self-checking bench for the low operating mode control bits
`default_nettype none
module test_operating_mode_low_control import omlc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LONG = 40;
  logic clock, rst, wr_en, miss, ack, core_req, dma_req, stop_exit;
  logic [23:0] wr_data, rd_data;
  logic [3:0] pins, chip_mode;
  logic [1:0] core_prio, dma_prio;
  logic switch_mode, bus_en, fetch_req, fetch_done, core_gnt, dma_gnt, stop_wait, resume, last;
  logic [15:0] pram_words, cache_base;
  logic [31:0] rnd;
  int errors, comparisons, cycles;
  omlc_ctrl #(.STOP_LONG_CYCLES(LONG)) dut (
    .CLOCK(clock), .RST(rst), .REG_WR_EN(wr_en), .REG_WR_DATA(wr_data), .REG_RD_DATA(rd_data),
    .MODE_PIN_HIGH(pins[3]), .MODE_PIN_TWO(pins[2]), .MODE_PIN_ONE(pins[1]),
    .MODE_PIN_LOW(pins[0]), .CHIP_MODE_BITS(chip_mode), .MEMORY_SWITCH_MODE(switch_mode),
    .PRAM_WORDS(pram_words), .CACHE_BASE_ADDR(cache_base), .EXT_BUS_ENABLE(bus_en),
    .CACHE_MISS(miss), .FETCH_REQ(fetch_req), .FETCH_ACK(ack), .FETCH_DONE(fetch_done),
    .CORE_BUS_REQ(core_req), .DMA_BUS_REQ(dma_req), .CORE_PRIORITY_FIELD(core_prio),
    .DMA_CHANNEL_PRIORITY(dma_prio), .CORE_BUS_GRANT(core_gnt), .DMA_BUS_GRANT(dma_gnt),
    .STOP_EXIT(stop_exit), .STOP_WAITING(stop_wait), .CORE_RESUME(resume)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      errors = errors + 1;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // expectations
  function automatic logic [23:0] rd_exp(input logic [23:0] d);
    return d & 24'h0007df; // only implemented bits, reserved bit reads zero
  endfunction
  function automatic logic [15:0] pram_exp(input logic sw);
    return sw ? 16'(4096 + 2048) : 16'(4096);
  endfunction
  // comparison and report
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic summarize();
    $display("counts: %0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one register write, returns at the settled point after the taking edge
  task automatic wr(input logic [23:0] d);
    @(posedge clock);
    wr_en <= 1'h1;
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'h0;
    @(negedge clock);
  endtask
  // cache miss with randomly stalled acks, counts words taken
  task automatic fetch(input logic [23:0] d, input int words, input logic done_exp);
    int n;
    logic seen;
    n = 0;
    seen = 1'h0;
    wr(d);
    @(posedge clock);
    miss <= 1'h1;
    @(posedge clock);
    miss <= 1'h0;
    ack <= 1'($urandom % 2);
    repeat (40) begin
      @(negedge clock);
      if (fetch_done === 1'h1) begin
        seen = 1'h1;
        break;
      end
      if ((fetch_req & ack) === 1'h1) n++;
      @(posedge clock);
      ack <= 1'($urandom % 2);
    end
    @(posedge clock);
    ack <= 1'h0;
    chk("fetch words", 24'(words), 24'(n));
    chk("fetch done", 24'(done_exp), 24'(seen));
  endtask
  // stop exit, counts waiting cycles before the resume pulse
  task automatic stop(input logic sel, input int exp);
    int n;
    int k;
    logic seen;
    n = 0;
    k = 0;
    seen = 1'h0;
    wr(sel ? 24'h000340 : 24'h000300);
    @(posedge clock);
    stop_exit <= 1'h1;
    @(posedge clock);
    stop_exit <= 1'h0;
    repeat (LONG + 20) begin
      @(negedge clock);
      k++;
      if (k == 1) chk("stop waiting", 24'h1, 24'(stop_wait));
      if (resume === 1'h1) begin
        seen = 1'h1;
        break;
      end
      if (stop_wait === 1'h1) n++;
    end
    chk("stop resume", 24'h1, 24'(seen));
    chk("stop delay", 24'(exp), 24'(n));
  endtask
  // both parties request, grants checked in the same cycle
  task automatic arb(input logic [1:0] md, cp, dp, input logic ec, ed);
    wr({14'h0000, md, 8'h00});
    @(posedge clock);
    core_req <= 1'h1;
    dma_req <= 1'h1;
    core_prio <= cp;
    dma_prio <= dp;
    @(negedge clock);
    chk("core grant", 24'(ec), 24'(core_gnt));
    chk("dma grant", 24'(ed), 24'(dma_gnt));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'h1;
    {wr_en, miss, ack, core_req, dma_req, stop_exit} = 6'h00;
    wr_data = 24'h000000;
    core_prio = 2'h0;
    dma_prio = 2'h0;
    errors = 0;
    comparisons = 0;
    cycles = 0;
    rnd = $urandom(32'h3c4e);
    pins = 4'($urandom);
    repeat (20) @(posedge clock);
    @(negedge clock);
    chk("reset read", 24'h000300, rd_data);
    chk("reset bus enable", 24'h1, 24'(bus_en));
    chk("reset cache base", 24'(3072), 24'(cache_base));
    @(posedge clock);
    rst <= 1'h0;
    repeat (2) @(negedge clock);
    chk("mode from pins", 24'(pins), 24'(chip_mode));
    chk("read with pins", 24'h000300 | 24'(pins), rd_data);
    $display("test reset done");
    // writes keep the reserved bit clear, the cache is taken as off (no enable here)
    for (int i = 0; i < 26; i++) begin
      if (i == 0) begin
        rnd = 32'hffffdf;
      end else if (i == 1) begin
        rnd = 32'h0;
      end else if (i == 25) begin
        rnd = 32'h000300; // leave switch mode off for the later tests
      end else begin
        rnd = $urandom & 32'hffffffdf;
      end
      wr(rnd[23:0]);
      chk("read back", rd_exp(rnd[23:0]), rd_data);
      chk("bus enable", 24'(!rnd[4]), 24'(bus_en));
      chk("switch mode", 24'(rnd[7]), 24'(switch_mode));
      @(negedge clock);
      chk("pram words", 24'(pram_exp(rnd[7])), 24'(pram_words));
      chk("cache base", 24'(pram_exp(rnd[7]) - 16'(1024)), 24'(cache_base));
      repeat (5) @(negedge clock);
    end
    $display("test register done");
    for (int i = 0; i < 4; i++) begin
      fetch(24'h000300, 1, 1'h1);
      fetch(24'h000700, 4, 1'h1);
    end
    fetch(24'h000710, 0, 1'h0);
    $display("test fetch done");
    arb(2'h1, 2'h3, 2'h0, 1'h0, 1'h1);
    arb(2'h3, 2'h0, 2'h3, 1'h1, 1'h0);
    arb(2'h0, 2'h3, 2'h1, 1'h1, 1'h0);
    arb(2'h0, 2'h0, 2'h2, 1'h0, 1'h1);
    // last contested grant under mode 10 went to the core, so dma takes this turn
    arb(2'h2, 2'h0, 2'h0, 1'h0, 1'h1);
    last = 1'h0;
    repeat (4) begin
      @(negedge clock);
      chk("equal turn", 24'(!last), 24'(core_gnt));
      chk("one grant", 24'h1, 24'(core_gnt ^ dma_gnt));
      last = core_gnt;
    end
    wr(24'h000310);
    chk("grants bus off", 24'h0, 24'({core_gnt, dma_gnt}));
    @(posedge clock);
    {core_req, dma_req} <= 2'h0;
    $display("test arbiter done");
    stop(1'h1, 16);
    stop(1'h0, LONG);
    $display("test stop done");
    summarize();
  end
endmodule
`default_nettype wire
